/* File: design/aba_core.v */
// alu datapath executing abs, adc and add with one parallel move
// assumes a classic wishbone master on the same clock; commands go to the
// command register and complete at the edge where the write is acked
`timescale 1ns/1ps
`include "aba_map.vh"

module aba_core #(
    parameter MEM_AW = 4                      // data memory index bits
) (
    input  wire        i_mclk,                // core clock, 125 MHz
    input  wire        i_rstn,                // async reset, active low
    input  wire        i_wb_cyc,              // wishbone cycle
    input  wire        i_wb_stb,              // wishbone strobe
    input  wire        i_wb_we,               // wishbone write
    input  wire [7:0]  i_wb_adr,              // byte address
    input  wire [31:0] i_wb_dat,              // write data
    input  wire [3:0]  i_wb_sel,              // byte enables
    output wire [31:0] o_wb_dat,              // read data
    output wire        o_wb_ack               // acknowledge
);

    // =================================================================
    // state
    reg  [31:0] cmd_q;
    reg         sat_q;
    reg  [7:0]  ccr_q;
    reg  [15:0] x0_q;
    reg  [15:0] y1_q;
    reg  [15:0] y0_q;
    reg  [35:0] acc_q [0:3];
    reg         ack_q;
    reg  [31:0] dat_q;
    integer     k;

    assign o_wb_ack = ack_q;
    assign o_wb_dat = dat_q;

    // =================================================================
    // helpers
    function [31:0] merge(input [31:0] old, input [31:0] nw, input [3:0] sel);
        merge = {sel[3] ? nw[31:24] : old[31:24], sel[2] ? nw[23:16] : old[23:16],
                 sel[1] ? nw[15:8]  : old[15:8],  sel[0] ? nw[7:0]   : old[7:0]};
    endfunction

    function ext_used(input [35:0] v);
        ext_used = !((&v[35:31]) || !(|v[35:31]));
    endfunction

    function [1:0] width_of(input [2:0] code);
        width_of = (code < `ABA_R_Y) ? `ABA_W16 :
                   (code == `ABA_R_Y) ? `ABA_W32 : `ABA_W36;
    endfunction

    // operand aligned to the destination width
    function [35:0] opnd(input [2:0] code, input [1:0] w);
        reg [15:0] r;
        reg [35:0] a;
        begin
            r = (code == `ABA_R_X0) ? x0_q : (code == `ABA_R_Y1) ? y1_q : y0_q;
            a = acc_q[code[1:0]];
            if (code < `ABA_R_Y) begin
                opnd = (w == `ABA_W36) ? {{4{r[15]}}, r, 16'h0000} :       // [RQ8]
                       (w == `ABA_W32) ? {4'h0, r, 16'h0000} : {20'h0_0000, r};
            end else if (code == `ABA_R_Y) begin
                opnd = (w == `ABA_W36) ? {{4{y1_q[15]}}, y1_q, y0_q} :    // [RQ8] [RQ3]
                       (w == `ABA_W32) ? {4'h0, y1_q, y0_q} : {20'h0_0000, y1_q};
            end else begin
                opnd = (w == `ABA_W36) ? a :                              // [RQ13]
                       (w == `ABA_W32) ? {4'h0, a[31:0]} :                // [RQ10]
                       {20'h0_0000, a[31:16]};                            // [RQ9]
            end
        end
    endfunction

    // =================================================================
    // bus decode
    wire        bus_req = i_wb_cyc & i_wb_stb;
    wire        wr_fire = bus_req & ack_q & i_wb_we;
    wire [31:0] cmd_d   = merge(cmd_q, i_wb_dat, i_wb_sel);
    wire        exec    = wr_fire && (i_wb_adr == `ABA_OFF_CMD);
    wire        acc_hit = (i_wb_adr[7:5] == `ABA_OFF_ACC);
    wire [1:0]  acc_idx = i_wb_adr[4:3];
    wire        mem_hit = (i_wb_adr[7:6] == `ABA_OFF_MEM);

    // =================================================================
    // command fields
    wire [1:0]  op   = cmd_d[`ABA_CMD_OP_LSB +: 2];
    wire [2:0]  src  = cmd_d[`ABA_CMD_SRC_LSB +: 3];
    wire [2:0]  dst  = cmd_d[`ABA_CMD_DST_LSB +: 3];
    wire [1:0]  pm   = cmd_d[`ABA_CMD_PM_LSB +: 2];
    wire        pinc = cmd_d[`ABA_CMD_PINC];
    wire [2:0]  preg = cmd_d[`ABA_CMD_PREG_LSB +: 3];
    wire [1:0]  wdt  = width_of(dst);

    // =================================================================
    // alu
    wire [35:0] alu_res;
    wire        f_c;
    wire        f_v;
    wire        f_z;
    wire        f_n;
    wire        f_u;
    wire        f_e;

    aba_alu u_alu (
        .i_op    (op),
        .i_width (wdt),
        .i_dval  (opnd(dst, wdt)),
        .i_sval  (opnd((op == `ABA_OP_ADC) ? `ABA_R_Y : src, wdt)), // [RQ14]
        .i_cin   ((op == `ABA_OP_ADC) & ccr_q[`ABA_CC_C]),          // [RQ5]
        .i_sat   (sat_q),
        .o_res   (alu_res),
        .o_c     (f_c),
        .o_v     (f_v),
        .o_z     (f_z),
        .o_n     (f_n),
        .o_u     (f_u),
        .o_e     (f_e)
    );

    // =================================================================
    // parallel move source word, with limiting of full accumulators
    reg  [15:0] pm_word;
    reg         pm_lim;
    reg         pm_sz;
    reg  [35:0] pm_acc;

    always @* begin
        // values taken before the alu result lands
        pm_acc  = acc_q[(preg == 3'h3 || preg == 3'h6) ? 2'h0 :      // [RQ15]
                        (preg == 3'h4 || preg == 3'h7) ? 2'h1 : 2'h2];
        pm_lim  = 1'b0;
        pm_sz   = 1'b0;
        case (preg)
            3'h0: pm_word = x0_q;
            3'h1: pm_word = y1_q;
            3'h2: pm_word = y0_q;
            3'h3, 3'h4, 3'h5: begin
                pm_sz   = pm_acc[30] ^ pm_acc[29];
                pm_lim  = ext_used(pm_acc);
                pm_word = !pm_lim ? pm_acc[31:16] : (pm_acc[35] ? 16'h8000 : 16'h7fff);
            end
            default: pm_word = pm_acc[31:16];
        endcase
    end

    // =================================================================
    // memory and pointer
    wire [15:0]       mem_rdata;
    wire [15:0]       mem_pdata;
    wire [MEM_AW-1:0] ptr;
    wire [MEM_AW-1:0] ofs;
    wire              pm_wr   = exec && (pm == `ABA_PM_WRITE);
    wire              bus_mwr = wr_fire && mem_hit;

    aba_xmem #(
        .AW (MEM_AW)
    ) u_xmem (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_we       (pm_wr | bus_mwr),
        .i_waddr    (pm_wr ? ptr : i_wb_adr[2 +: MEM_AW]),
        .i_wdata    (pm_wr ? pm_word : cmd_d[15:0]),
        .i_raddr    (i_wb_adr[2 +: MEM_AW]),
        .o_rdata    (mem_rdata),
        .o_pdata    (mem_pdata),
        .i_ptr_we   (wr_fire && (i_wb_adr == `ABA_OFF_PTR)),
        .i_ofs_we   (wr_fire && (i_wb_adr == `ABA_OFF_OFS)),
        .i_load     (cmd_d[MEM_AW-1:0]),
        .i_step     (exec && (pm != `ABA_PM_NONE)),               // [RQ19]
        .i_step_ofs (pinc),
        .o_ptr      (ptr),
        .o_ofs      (ofs)
    );

    // =================================================================
    // read mux, unmapped reads return zero
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        if (acc_hit) begin
            rd_mux = i_wb_adr[2] ? {28'h000_0000, acc_q[acc_idx][35:32]}
                                 : acc_q[acc_idx][31:0];
        end else if (mem_hit) begin
            rd_mux = {16'h0000, mem_rdata};
        end else begin
            case (i_wb_adr)
                `ABA_OFF_CMD: rd_mux = cmd_q;
                `ABA_OFF_OMR: rd_mux = {31'h0000_0000, sat_q};
                `ABA_OFF_CCR: rd_mux = {24'h00_0000, ccr_q};
                `ABA_OFF_X0:  rd_mux = {16'h0000, x0_q};
                `ABA_OFF_Y1:  rd_mux = {16'h0000, y1_q};
                `ABA_OFF_Y0:  rd_mux = {16'h0000, y0_q};
                `ABA_OFF_PTR: rd_mux = {{(32-MEM_AW){1'b0}}, ptr};
                `ABA_OFF_OFS: rd_mux = {{(32-MEM_AW){1'b0}}, ofs};
                default:      rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // =================================================================
    // wishbone answer: ack one cycle after the request, then drop
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req & ~ack_q) begin
                dat_q <= rd_mux;
            end
        end
    end

    // =================================================================
    // register file, command execution in a single edge
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_q <= 32'h0000_0000;
            sat_q <= `ABA_RST_OMR;
            ccr_q <= `ABA_RST_CCR;
            x0_q  <= 16'h0000;
            y1_q  <= 16'h0000;
            y0_q  <= 16'h0000;
            for (k = 0; k < 4; k = k + 1) begin
                acc_q[k] <= 36'h0_0000_0000;
            end
        end else if (wr_fire) begin
            if (acc_hit && i_wb_adr[2]) begin
                acc_q[acc_idx][35:32] <= cmd_d[3:0];
            end else if (acc_hit) begin
                acc_q[acc_idx][31:0] <= cmd_d;
            end
            case (i_wb_adr)
                `ABA_OFF_OMR: sat_q <= cmd_d[`ABA_OMR_SAT];
                `ABA_OFF_CCR: ccr_q <= cmd_d[7:0];
                `ABA_OFF_X0:  x0_q  <= cmd_d[15:0];
                `ABA_OFF_Y1:  y1_q  <= cmd_d[15:0];
                `ABA_OFF_Y0:  y0_q  <= cmd_d[15:0];
                default: ;
            endcase
            if (exec) begin
                cmd_q <= cmd_d;
                // alu writeback, finished in this edge
                if (dst < `ABA_R_Y) begin                                     // [RQ1]
                    case (dst)
                        `ABA_R_X0: x0_q <= alu_res[15:0];                    // [RQ9]
                        `ABA_R_Y1: y1_q <= alu_res[15:0];
                        default:   y0_q <= alu_res[15:0];
                    endcase
                end else if (dst == `ABA_R_Y) begin
                    y1_q <= alu_res[31:16];                                   // [RQ10]
                    y0_q <= alu_res[15:0];
                end else begin
                    acc_q[dst[1:0]] <= alu_res;                               // [RQ16] [RQ3]
                end
                // condition byte; abs leaves carry alone
                if (op != `ABA_OP_ABS) begin
                    ccr_q[`ABA_CC_C] <= f_c;                                  // [RQ14] [RQ18]
                end
                ccr_q[`ABA_CC_V]  <= f_v;                                     // [RQ18]
                ccr_q[`ABA_CC_Z]  <= f_z;
                ccr_q[`ABA_CC_N]  <= f_n;
                ccr_q[`ABA_CC_U]  <= f_u;
                ccr_q[`ABA_CC_E]  <= f_e;
                ccr_q[`ABA_CC_L]  <= ccr_q[`ABA_CC_L] | f_v |                 // [RQ11]
                                     (pm_wr & pm_lim);
                ccr_q[`ABA_CC_SZ] <= ccr_q[`ABA_CC_SZ] | (pm_wr & pm_sz);
                // parallel read lands after the alu result
                if (pm == `ABA_PM_READ) begin                                 // [RQ19]
                    case (preg)
                        3'h0: x0_q <= mem_pdata;
                        3'h1: y1_q <= mem_pdata;
                        3'h2: y0_q <= mem_pdata;
                        3'h3: acc_q[0] <= {{4{mem_pdata[15]}}, mem_pdata, 16'h0000};
                        3'h4: acc_q[1] <= {{4{mem_pdata[15]}}, mem_pdata, 16'h0000};
                        3'h5: acc_q[2] <= {{4{mem_pdata[15]}}, mem_pdata, 16'h0000};
                        3'h6: acc_q[0][31:16] <= mem_pdata;
                        default: acc_q[1][31:16] <= mem_pdata;
                    endcase
                end
            end
        end
    end

endmodule

/* File: design/aba_map.vh */
// constants for the absolute value / add / add-with-carry datapath
// assumes a classic wishbone slave with 32-bit data and byte addresses
//
// Overview of operation
// RQ1: abs, adc and add, with any parallel move, finish in one cycle, one word.
// RQ2: software never names one register as alu destination and parallel read target.
// RQ3: adc adds sign-extended 32-bit pair, carry flag and accumulator into accumulator.
// RQ4: adc never saturates its result, whatever the saturation enable says.
// RQ5: adc carry enters at bit 0; the pair registers stay untouched.
// RQ6: adc flags: n from bit 35, c out of 35, z, v, l, e.
// RQ7: adc carry is valid for multi-precision only when bits 31..35 agree.
// RQ8: add to accumulator pads 16-bit sources with low zeros; pair only sign-extended.
// RQ9: add to a 16-bit register is 16-bit; accumulators give only middle word.
// RQ10: add to the pair ignores the accumulator source extension.
// RQ11: add flags: n top bit, c carry out, z, v, u, e, l.
// RQ12: add carry is exact for accumulator sources, else needs sign-extended destination.
// RQ13: register-to-register add is a full 36-bit add in one cycle.
// RQ14: adc with pair source and accumulator destination updates carry.
// RQ15: a parallel move from the alu destination uses its value before the operation.
// RQ16: abs replaces the destination with its magnitude in the same register.
// RQ17: abs of most negative value overflows; saturates when enabled, else unchanged.
// RQ18: condition byte: c v z n u e l in bits 0..6, size flag bit 7.
// RQ19: parallel moves read or write memory via pointer, post-increment by one or offset.
`ifndef ABA_MAP_VH
`define ABA_MAP_VH

// =====================================================================
// register byte offsets
`define ABA_OFF_CMD     8'h00
`define ABA_OFF_OMR     8'h04
`define ABA_OFF_CCR     8'h08
`define ABA_OFF_X0      8'h0c
`define ABA_OFF_Y1      8'h10
`define ABA_OFF_Y0      8'h14
`define ABA_OFF_ACC     3'h1
`define ABA_OFF_PTR     8'h40
`define ABA_OFF_OFS     8'h44
`define ABA_OFF_MEM     2'h2

// =====================================================================
// command word fields
`define ABA_CMD_OP_LSB   0
`define ABA_CMD_SRC_LSB  4
`define ABA_CMD_DST_LSB  8
`define ABA_CMD_PM_LSB   12
`define ABA_CMD_PINC     14
`define ABA_CMD_PREG_LSB 16

// =====================================================================
// opcodes, move kinds, operand codes, widths
`define ABA_OP_ABS   2'h0
`define ABA_OP_ADC   2'h1
`define ABA_OP_ADD   2'h2
`define ABA_PM_NONE  2'h0
`define ABA_PM_READ  2'h1
`define ABA_PM_WRITE 2'h2
`define ABA_R_X0     3'h0
`define ABA_R_Y1     3'h1
`define ABA_R_Y0     3'h2
`define ABA_R_Y      3'h3
`define ABA_W16      2'h0
`define ABA_W32      2'h1
`define ABA_W36      2'h2

// =====================================================================
// condition byte bit positions and reset values
`define ABA_CC_C  0
`define ABA_CC_V  1
`define ABA_CC_Z  2
`define ABA_CC_N  3
`define ABA_CC_U  4
`define ABA_CC_E  5
`define ABA_CC_L  6
`define ABA_CC_SZ 7
`define ABA_OMR_SAT 0
`define ABA_RST_CCR 8'h00
`define ABA_RST_OMR 1'b0

`endif

/* File: design/aba_alu.v */
// combinational arithmetic for abs, adc and add at 16, 32 or 36 bits
// assumes operands arrive already aligned and extended by the caller
`timescale 1ns/1ps
`include "aba_map.vh"

module aba_alu (
    input  wire [1:0]  i_op,    // operation code
    input  wire [1:0]  i_width, // result width code
    input  wire [35:0] i_dval,  // destination operand
    input  wire [35:0] i_sval,  // source operand
    input  wire        i_cin,   // carry flag in
    input  wire        i_sat,   // saturation enable
    output reg  [35:0] o_res,   // result
    output reg         o_c,     // carry out
    output reg         o_v,     // overflow
    output reg         o_z,     // zero
    output reg         o_n,     // negative
    output reg         o_u,     // unnormalized
    output reg         o_e      // extension in use
);

    // =================================================================
    // width helpers
    function [35:0] wmask(input [1:0] w);
        case (w)
            `ABA_W16: wmask = 36'h0_0000_ffff;
            `ABA_W32: wmask = 36'h0_ffff_ffff;
            default:  wmask = 36'hf_ffff_ffff;
        endcase
    endfunction

    function msb(input [35:0] x, input [1:0] w);
        case (w)
            `ABA_W16: msb = x[15];
            `ABA_W32: msb = x[31];
            default:  msb = x[35];
        endcase
    endfunction

    reg [35:0] m;
    reg [35:0] dm;
    reg [35:0] sm;
    reg [36:0] sum;
    reg [35:0] neg;
    reg [35:0] minv;
    reg [35:0] maxv;

    // =================================================================
    // result and flags
    always @* begin
        m    = wmask(i_width);
        dm   = i_dval & m;
        sm   = i_sval & m;
        minv = m ^ (m >> 1);
        maxv = (i_width == `ABA_W16) ? 36'h0_0000_7fff : 36'h0_7fff_ffff;
        neg  = (~dm + 36'h0_0000_0001) & m;
        // carry enters at bit 0 of the masked add
        sum  = {1'b0, dm} + {1'b0, sm} + {36'h0_0000_0000, i_cin}; // [RQ5] [RQ13]
        o_c  = 1'b0;
        o_v  = 1'b0;
        o_res = dm;
        case (i_op)
            `ABA_OP_ABS: begin
                // most negative input has no magnitude
                if (dm == minv) begin
                    o_v   = 1'b1;                           // [RQ17]
                    o_res = i_sat ? maxv : dm;              // [RQ17]
                end else begin
                    o_res = msb(dm, i_width) ? neg : dm;    // [RQ16]
                end
            end
            `ABA_OP_ADC, `ABA_OP_ADD: begin
                // never limited, so multi-word chains stay exact
                o_res = sum[35:0] & m;                      // [RQ4] [RQ3]
                o_c   = (i_width == `ABA_W16) ? sum[16] :
                        (i_width == `ABA_W32) ? sum[32] : sum[36]; // [RQ6] [RQ11] [RQ7] [RQ12]
                o_v   = (msb(dm, i_width) == msb(sm, i_width)) &&
                        (msb(o_res, i_width) != msb(dm, i_width));
            end
            default: o_res = dm;
        endcase
        o_z = (o_res == 36'h0_0000_0000);                   // [RQ6] [RQ11]
        o_n = msb(o_res, i_width);                          // [RQ6] [RQ11]
        o_u = (i_width == `ABA_W16) ? ~(o_res[15] ^ o_res[14]) :
              ~(o_res[31] ^ o_res[30]);
        o_e = (i_width == `ABA_W36) &&
              !((&o_res[35:31]) || !(|o_res[35:31]));
    end

endmodule

/* File: design/aba_xmem.v */
// data memory in flip-flops with the parallel-move pointer and offset
// assumes one write port shared by the core and the bus, chosen by the core
`timescale 1ns/1ps

module aba_xmem #(
    parameter AW = 4                     // address bits
) (
    input  wire          i_mclk,         // core clock
    input  wire          i_rstn,         // async reset, active low
    input  wire          i_we,           // memory write strobe
    input  wire [AW-1:0] i_waddr,        // write index
    input  wire [15:0]   i_wdata,        // write data
    input  wire [AW-1:0] i_raddr,        // bus read index
    output wire [15:0]   o_rdata,        // bus read data
    output wire [15:0]   o_pdata,        // word at pointer
    input  wire          i_ptr_we,       // pointer load
    input  wire          i_ofs_we,       // offset load
    input  wire [AW-1:0] i_load,         // load value
    input  wire          i_step,         // post-update pointer
    input  wire          i_step_ofs,     // step by offset, not by one
    output wire [AW-1:0] o_ptr,          // pointer
    output wire [AW-1:0] o_ofs           // offset
);

    reg [15:0]   mem_q [0:(1<<AW)-1];
    reg [AW-1:0] ptr_q;
    reg [AW-1:0] ofs_q;
    integer      i;

    assign o_rdata = mem_q[i_raddr];
    assign o_pdata = mem_q[ptr_q];
    assign o_ptr   = ptr_q;
    assign o_ofs   = ofs_q;

    // =================================================================
    // storage and pointer post-update
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ptr_q <= {AW{1'b0}};
            ofs_q <= {AW{1'b0}};
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem_q[i] <= 16'h0000;
            end
        end else begin
            if (i_we) begin
                mem_q[i_waddr] <= i_wdata;
            end
            if (i_ptr_we) begin
                ptr_q <= i_load;
            end else if (i_step) begin
                ptr_q <= ptr_q + (i_step_ofs ? ofs_q : {{(AW-1){1'b0}}, 1'b1}); // [RQ19]
            end
            if (i_ofs_we) begin
                ofs_q <= i_load;
            end
        end
    end

endmodule

/* File: tb/aba_core_checker.sv */
// bus-port checks for the alu datapath
// assumes binding onto aba_core; one clock, async active-low reset
`timescale 1ns/1ps
module aba_core_checker (
    input wire        i_mclk,   // core clock
    input wire        i_rstn,   // reset, active low
    input wire        i_wb_cyc, // cycle
    input wire        i_wb_stb, // strobe
    input wire        i_wb_we,  // write
    input wire [7:0]  i_wb_adr, // byte address
    input wire [31:0] o_wb_dat, // read data
    input wire        o_wb_ack  // acknowledge
);
    // =====================================
    // handshake timing and read widths
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    wire req = i_wb_cyc && i_wb_stb;
    wire rd  = o_wb_ack && !i_wb_we;
    ack_next_cycle_a: assert property (req && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered next cycle");
    ack_single_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    ack_has_cause_a: assert property (o_wb_ack |-> $past(req))
        else $error("ack without request");
    dat_holds_a: assert property (!(req && !o_wb_ack) |=> $stable(o_wb_dat))
        else $error("read data moved without request");
    ccr_width_a: assert property (rd && i_wb_adr == 8'h08 |-> o_wb_dat[31:8] == 0)
        else $error("condition byte too wide");
    word_width_a: assert property (rd && i_wb_adr inside {8'h0c, 8'h10, 8'h14}
        |-> o_wb_dat[31:16] == 0)
        else $error("input word too wide");
    ext_width_a: assert property (rd && i_wb_adr[7:5] == 3'h1 && i_wb_adr[2]
        |-> o_wb_dat[31:4] == 0)
        else $error("extension too wide");
    mem_width_a: assert property (rd && i_wb_adr[7:6] == 2'h2 |-> o_wb_dat[31:16] == 0)
        else $error("memory word too wide");
endmodule
bind aba_core aba_core_checker u_chk (.i_mclk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .o_wb_dat, .o_wb_ack);

/* File: tb/aba_bus_master.sv */
// classic wishbone master standing in for the decoder side
// assumes the top is tb, owning errors and wrap_up
`timescale 1ns/1ps
module aba_bus_master (
    input  wire         i_mclk, // core clock
    input  wire         i_ack,  // slave ack
    input  wire  [31:0] i_dat,  // slave read data
    output logic        o_cyc,  // cycle
    output logic        o_stb,  // strobe
    output logic        o_we,   // write
    output logic [7:0]  o_adr,  // byte address
    output logic [31:0] o_dat,  // write data
    output logic [3:0]  o_sel   // byte enables
);
    // =====================================
    // idle bus at time zero
    initial begin
        {o_cyc, o_stb, o_we, o_adr, o_dat} = '0;
        o_sel = 4'hf;
    end
    // one cycle, held until ack is sampled; released data inverted
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge i_mclk);
        {o_cyc, o_stb, o_we, o_adr, o_dat} <= {2'b11, w, a, d};
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (i_ack !== 1'b1 && n < 16);
        q = i_dat;
        {o_cyc, o_stb, o_dat} <= {2'b00, ~d};
        if (i_ack !== 1'b1) begin
            tb.errors++;
            tb.wrap_up();
        end
    endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for aba_core over wishbone
// assumes the design header and the bus master model
`timescale 1ns/1ps
`include "aba_map.vh"
module tb;
    logic        mclk, rstn;
    wire         cyc, stb, we, ack;
    wire  [7:0]  adr;
    wire  [31:0] wdat, rdat;
    wire  [3:0]  sel;
    int          errors = 0, check_count = 0;
    aba_core #(.MEM_AW(4)) u_aba_core (.i_mclk(mclk), .i_rstn(rstn), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_dat(rdat), .o_wb_ack(ack));
    aba_bus_master u_aba_bus_master (.i_mclk(mclk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc),
        .o_stb(stb), .o_we(we), .o_adr(adr), .o_dat(wdat), .o_sel(sel));
    // =====================================
    // helpers
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_aba_bus_master.xfer(1'b1, a, d, q);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        u_aba_bus_master.xfer(1'b0, a, 32'h0, q);
        chk({4'h0, q & m}, {4'h0, e});
    endtask
    task automatic set_acc(input logic [7:0] a, input logic [35:0] v);
        wr(a, v[31:0]);
        wr(a + 8'h04, {28'h0, v[35:32]});
    endtask
    task automatic chk_acc(input logic [7:0] a, input logic [35:0] e);
        logic [31:0] lo, hi;
        u_aba_bus_master.xfer(1'b0, a, 32'h0, lo);
        u_aba_bus_master.xfer(1'b0, a + 8'h04, 32'h0, hi);
        chk({hi[3:0], lo}, e);
    endtask
    function automatic [31:0] cmd(input [1:0] op, input [2:0] s, input [2:0] d,
                                  input [1:0] pm, input [2:0] mr);
        cmd = {13'h0, mr, 2'h0, pm, 1'b0, d, 1'b0, s, 2'h0, op};
    endfunction
    // =====================================
    // scenarios
    task automatic t_abs;
        wr(8'h04, 32'h0);
        set_acc(8'h20, 36'hf_ffff_fff2);
        wr(8'h00, cmd(`ABA_OP_ABS, 3'h0, 3'h4, 2'h0, 3'h0));
        chk_acc(8'h20, 36'h0_0000_000e);
        set_acc(8'h20, 36'h8_0000_0000);
        wr(8'h00, cmd(`ABA_OP_ABS, 3'h0, 3'h4, 2'h0, 3'h0));
        chk_acc(8'h20, 36'h8_0000_0000);
        rdm(8'h08, 32'h2, 32'h2);
        wr(8'h04, 32'h1);
        wr(8'h00, cmd(`ABA_OP_ABS, 3'h0, 3'h4, 2'h0, 3'h0));
        chk_acc(8'h20, 36'h0_7fff_ffff);
        $display("abs test done");
    endtask
    task automatic t_adc(input [31:0] y, input [35:0] a, input [7:0] c,
                         input [35:0] ea, input [7:0] ec);
        wr(8'h10, {16'h0, y[31:16]});
        wr(8'h14, {16'h0, y[15:0]});
        set_acc(8'h20, a);
        wr(8'h08, {24'h0, c});
        wr(8'h00, cmd(`ABA_OP_ADC, 3'h3, 3'h4, 2'h0, 3'h0));
        chk_acc(8'h20, ea);
        rdm(8'h08, 32'hff, {24'h0, ec});
        rdm(8'h10, 32'hffff, {16'h0, y[31:16]});
        rdm(8'h14, 32'hffff, {16'h0, y[15:0]});
        $display("adc test done");
    endtask
    task automatic t_add;
        wr(8'h08, 32'h0);
        wr(8'h40, 32'h0);
        wr(8'h0c, 32'h2);
        set_acc(8'h20, 36'h0_0058_1234);
        wr(8'h00, cmd(`ABA_OP_ADD, 3'h0, 3'h4, 2'h2, 3'h6)); // move is a write
        chk_acc(8'h20, 36'h0_005a_1234);
        rdm(8'h80, 32'hffff, 32'h0058);
        rdm(8'h40, 32'hf, 32'h1);
        wr(8'h10, 32'h1);
        set_acc(8'h20, 36'h7_1234_5678);
        wr(8'h00, cmd(`ABA_OP_ADD, 3'h4, 3'h1, 2'h0, 3'h0));
        rdm(8'h10, 32'hffff, 32'h1235);
        set_acc(8'h20, 36'h0_ffff_ffff);
        set_acc(8'h28, 36'h0_0000_0001);
        wr(8'h00, cmd(`ABA_OP_ADD, 3'h5, 3'h4, 2'h0, 3'h0));
        chk_acc(8'h20, 36'h1_0000_0000);
        rdm(8'h08, 32'hff, 32'h30);
        $display("add test done");
    endtask
    // =====================================
    // clock, reset, sequence, verdict
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        t_abs();
        t_adc(32'h2000_8000, 36'h0_2000_8000, 8'h01, 36'h0_4001_0001, 8'h00);
        t_adc(32'h0000_0001, 36'h7_ffff_ffff, 8'h00, 36'h8_0000_0000, 8'h7a);
        t_adc(32'h0000_0001, 36'hf_ffff_ffff, 8'h00, 36'h0_0000_0000, 8'h15);
        t_add();
        wrap_up();
    end
endmodule
